/* File: rtl/hbwp_map.svh */
// Purpose: Constants for the host bus word pair port
// Assumes: Included by bare name from design files
// Notes: Definitions only
`ifndef HBWP_MAP_SVH
`define HBWP_MAP_SVH

// Host data bus and internal word widths
`define HBWP_HALF_W 16
`define HBWP_WORD_W 32
// Field positions of the two halves in an internal word
`define HBWP_LO_LSB 0
`define HBWP_HI_LSB 16
// Byte width used by the endian reorder
`define HBWP_BYTE_W 8
// Reset value of synchronised active-low pins (idle, not asserted)
`define HBWP_PIN_IDLE 1'b1
// Reset value of synchronised data-like pins
`define HBWP_PIN_ZERO 1'b0
// Default address width (pins A[ADDR_W-1:1])
`define HBWP_ADDR_W 10
// Default number of interrupt sources
`define HBWP_IRQ_N 8

`endif

/* File: rtl/hbwp_pkg.sv */
// Purpose: Types for the host bus word pair port
// Assumes: Nothing beyond the map header
// Notes: Pairing state of a 32-bit transfer
package hbwp_pkg;

   // Which half of a pair is outstanding
   typedef enum logic [1:0] {
      pair_idle = 2'b00,    // No half outstanding
      pair_wr_half = 2'b01, // One write half held
      pair_rd_half = 2'b10  // One read half delivered, word latched
   } hbwp_pair_type;

endpackage : hbwp_pkg

/* File: rtl/hbwp_sync.sv */
// Purpose: Two-flop synchroniser for a bundle of host pins
// Assumes: Each bit is an independent level from outside clk_sys
// Notes: Stage one is read only by stage two
`timescale 1ns/1ps
module hbwp_sync #(
   parameter int WIDTH = 1,
   parameter logic [WIDTH-1:0] RST_VAL = '0
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Asynchronous inputs
   input wire logic [WIDTH-1:0] pin_in,
   // Synchronised outputs
   output logic [WIDTH-1:0] pin_sync
);

   genvar gi;

   // One two-stage chain per bit
   generate
      for (gi = 0; gi < WIDTH; gi = gi + 1) begin : g_bit
         logic meta_reg; // First stage, may go metastable
         logic meta_next;
         logic sync_reg; // Second stage, safe to use
         logic sync_next;

         // Next values of both stages
         always_comb begin
            meta_next = pin_in[gi];
            sync_next = meta_reg;
         end

         // Register stages, reset to this bit of RST_VAL
         always_ff @(posedge clk_sys) begin
            if (!nrst) begin
               meta_reg <= RST_VAL[gi];
               sync_reg <= RST_VAL[gi];
            end else begin
               meta_reg <= meta_next;
               sync_reg <= sync_next;
            end
         end

         assign pin_sync[gi] = sync_reg;
      end
   endgenerate

endmodule : hbwp_sync

/* File: rtl/hbwp_port.sv */
// Purpose: Host bus port, 16-bit asynchronous slave to 32-bit internal access
// Assumes: Host strobes are slow against clk_sys (25 MHz); internal register
//          and FIFO read data is valid the cycle after the read pulse
// Notes: All host pins are synchronised before use
// What this block does
// - Sixteen-bit asynchronous SRAM-style host data bus.
// - Endian chosen per access from select pin.
// - FIFO select routes writes TX, reads RX.
// - Normal mode decodes registers only.
// - Halves accepted in either order.
// - Same half written twice discards transfer.
// - One internal 32-bit write after both halves.
// - Same half read twice resets pair tracking.
// - Sixteen-bit readable registers allow single reads.
// - Interrupt sources observable, individually enabled onto pin.
// - Select low little endian, high big.
// - Bytes reordered by select and A1.
// - Writes ignored after reset until a read.
`timescale 1ns/1ps
`include "hbwp_map.svh"
module hbwp_port #(
   parameter int ADDR_W = `HBWP_ADDR_W,
   parameter int IRQ_N = `HBWP_IRQ_N
) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Host bus pins
   input wire logic host_cs_n,
   input wire logic host_rd_n,
   input wire logic host_wr_n,
   input wire logic [ADDR_W-1:1] host_addr,
   input wire logic [`HBWP_HALF_W-1:0] host_data_in,
   output logic [`HBWP_HALF_W-1:0] host_data_out,
   output logic host_data_oe,
   input wire logic end_sel,
   input wire logic fifo_sel,
   // Internal register access
   output logic [ADDR_W-3:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [`HBWP_WORD_W-1:0] wr_data,
   input wire logic [`HBWP_WORD_W-1:0] reg_rdata,
   input wire logic reg_rd16,
   // Internal data FIFOs
   output logic txf_wr,
   output logic rxf_rd,
   input wire logic [`HBWP_WORD_W-1:0] rxf_rdata,
   // Interrupts
   input wire logic [IRQ_N-1:0] irq_src,
   input wire logic [IRQ_N-1:0] irq_en,
   output logic [IRQ_N-1:0] irq_stat,
   output logic irq
);

   localparam int SYNC_W = ADDR_W + `HBWP_HALF_W + 4;

   // Reverse byte order of an internal word
   function automatic logic [`HBWP_WORD_W-1:0] bswap(input logic [`HBWP_WORD_W-1:0] w);
      logic [`HBWP_WORD_W-1:0] r;
      r = '0;
      for (int i = 0; i < 4; i++) begin
         r[i*`HBWP_BYTE_W +: `HBWP_BYTE_W] = w[(3-i)*`HBWP_BYTE_W +: `HBWP_BYTE_W];
      end
      return r;
   endfunction : bswap

   // Pick the host half of an internal word
   function automatic logic [`HBWP_HALF_W-1:0] to_host(input logic [`HBWP_WORD_W-1:0] w,
                                                       input logic a1, input logic big);
      logic [`HBWP_WORD_W-1:0] r;
      r = big ? bswap(w) : w;
      return a1 ? r[`HBWP_HI_LSB +: `HBWP_HALF_W] : r[`HBWP_LO_LSB +: `HBWP_HALF_W];
   endfunction : to_host

   // Merge one host half into an internal word
   function automatic logic [`HBWP_WORD_W-1:0] from_host(input logic [`HBWP_WORD_W-1:0] w,
                                                         input logic [`HBWP_HALF_W-1:0] h,
                                                         input logic a1, input logic big);
      logic [`HBWP_WORD_W-1:0] r;
      r = big ? bswap(w) : w;
      if (a1) begin
         r[`HBWP_HI_LSB +: `HBWP_HALF_W] = h;
      end else begin
         r[`HBWP_LO_LSB +: `HBWP_HALF_W] = h;
      end
      return big ? bswap(r) : r;
   endfunction : from_host

   // Synchronised pins
   logic [SYNC_W-1:0] pin_raw;
   logic [SYNC_W-1:0] pin_sync;
   logic s_cs_n;
   logic s_rd_n;
   logic s_wr_n;
   logic s_end;
   logic s_fifo;
   logic [ADDR_W-1:1] s_addr;
   logic [`HBWP_HALF_W-1:0] s_data;

   assign pin_raw = {host_cs_n, host_rd_n, host_wr_n, end_sel, fifo_sel, host_addr, host_data_in};
   assign {s_cs_n, s_rd_n, s_wr_n, s_end, s_fifo, s_addr, s_data} = pin_sync;

   // All host pins cross through two flops; strobes idle high
   hbwp_sync #(
      .WIDTH(SYNC_W),
      .RST_VAL({{3{`HBWP_PIN_IDLE}}, {(SYNC_W-3){`HBWP_PIN_ZERO}}})
   ) u_sync (
      .clk_sys(clk_sys),
      .nrst(nrst),
      .pin_in(pin_raw),
      .pin_sync(pin_sync)
   );

   // Cycle detection
   logic rd_act;  // Read strobe asserted
   logic wr_act;  // Write strobe asserted
   logic rd_start; // First cycle of a host read
   logic wr_start; // First cycle of a host write
   logic same_word; // Access hits the word and mode held by the pair
   logic other_half; // Access hits the half not yet used
   logic do_fetch; // This read starts a fresh internal read
   logic do_open; // This write opens a fresh pair

   // Edge detector state; idle is strobe inactive, so no false edge after reset
   logic rd_act_reg;
   logic rd_act_next;
   logic wr_act_reg;
   logic wr_act_next;

   // Pair tracking state
   hbwp_pkg::hbwp_pair_type pair_reg; // Outstanding half, if any
   hbwp_pkg::hbwp_pair_type pair_next;
   logic [`HBWP_WORD_W-1:0] word_reg; // Latched read word or assembled write word
   logic [`HBWP_WORD_W-1:0] word_next;
   logic [ADDR_W-3:0] addr_reg; // Word address of the pair
   logic [ADDR_W-3:0] addr_next;
   logic half_reg; // A1 of the first half
   logic half_next;
   logic big_reg; // Endian select of the pair
   logic big_next;
   logic fifo_reg; // FIFO select of the pair
   logic fifo_next;
   logic rd16_reg; // Latched word is 16-bit readable
   logic rd16_next;
   logic rd_seen_reg; // A read has happened since reset
   logic rd_seen_next;
   logic fetch1_reg; // Read pulse stands this cycle
   logic fetch1_next;
   logic fetch2_reg; // Internal read data valid this cycle
   logic fetch2_next;

   // Output flops
   logic [`HBWP_HALF_W-1:0] data_out_reg;
   logic [`HBWP_HALF_W-1:0] data_out_next;
   logic oe_reg;
   logic oe_next;
   logic reg_rd_reg;
   logic reg_rd_next;
   logic rxf_rd_reg;
   logic rxf_rd_next;
   logic reg_wr_reg;
   logic reg_wr_next;
   logic txf_wr_reg;
   logic txf_wr_next;
   logic [`HBWP_WORD_W-1:0] wr_data_reg;
   logic [`HBWP_WORD_W-1:0] wr_data_next;

   // Interrupt state
   logic [IRQ_N-1:0] irq_stat_reg;
   logic [IRQ_N-1:0] irq_stat_next;
   logic irq_reg;
   logic irq_next;

   // Strobe decode on synchronised pins
   assign rd_act = !s_cs_n && !s_rd_n;
   assign wr_act = !s_cs_n && !s_wr_n;
   assign rd_start = rd_act && !rd_act_reg;
   assign wr_start = wr_act && !wr_act_reg;
   // Any change besides A1 breaks the pair and starts afresh
   assign same_word = (s_addr[ADDR_W-1:2] == addr_reg) && (s_fifo == fifo_reg) &&
                      (s_end == big_reg);
   assign other_half = s_addr[1] != half_reg;

   // Next values of the edge detectors
   always_comb begin
      rd_act_next = rd_act;
      wr_act_next = wr_act;
   end

   // Register the edge detectors
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         rd_act_reg <= 1'b0;
         wr_act_reg <= 1'b0;
      end else begin
         rd_act_reg <= rd_act_next;
         wr_act_reg <= wr_act_next;
      end
   end

   // Next values of the pair tracking and access pulses
   always_comb begin
      pair_next = pair_reg;
      word_next = word_reg;
      addr_next = addr_reg;
      half_next = half_reg;
      big_next = big_reg;
      fifo_next = fifo_reg;
      rd16_next = rd16_reg;
      rd_seen_next = rd_seen_reg;
      fetch1_next = 1'b0;
      fetch2_next = fetch1_reg;
      data_out_next = data_out_reg;
      oe_next = rd_act;
      reg_rd_next = 1'b0;
      rxf_rd_next = 1'b0;
      reg_wr_next = 1'b0;
      txf_wr_next = 1'b0;
      wr_data_next = wr_data_reg;
      do_fetch = 1'b0;
      do_open = 1'b0;
      // Internal read data is taken the cycle after the pulse
      if (fetch2_reg) begin
         word_next = fifo_reg ? rxf_rdata : reg_rdata;
         rd16_next = reg_rd16 && !fifo_reg;
         data_out_next = to_host(fifo_reg ? rxf_rdata : reg_rdata, half_reg, big_reg);
      end
      if (rd_start) begin
         rd_seen_next = 1'b1;
         case (pair_reg)
            hbwp_pkg::pair_rd_half: begin
               if (same_word && other_half) begin
                  // Second half from the latched word, no new internal read
                  data_out_next = to_host(word_reg, s_addr[1], big_reg);
                  pair_next = hbwp_pkg::pair_idle;
               end else if (same_word && !rd16_reg) begin
                  // Same half twice: result invalid, tracking cleared
                  pair_next = hbwp_pkg::pair_idle;
               end else begin
                  do_fetch = 1'b1;
               end
            end
            default: begin
               // An open write half is abandoned by a read
               do_fetch = 1'b1;
            end
         endcase
      end else if (wr_start && rd_seen_reg) begin
         case (pair_reg)
            hbwp_pkg::pair_wr_half: begin
               if (same_word && other_half) begin
                  // Both halves in: one internal 32-bit write
                  wr_data_next = from_host(word_reg, s_data, s_addr[1], big_reg);
                  reg_wr_next = !fifo_reg;
                  txf_wr_next = fifo_reg;
                  pair_next = hbwp_pkg::pair_idle;
               end else if (same_word) begin
                  // Same half twice: transfer dropped
                  pair_next = hbwp_pkg::pair_idle;
               end else begin
                  do_open = 1'b1;
               end
            end
            default: begin
               do_open = 1'b1;
            end
         endcase
      end
      // Fresh internal read, data returns two cycles later
      if (do_fetch) begin
         addr_next = s_addr[ADDR_W-1:2];
         half_next = s_addr[1];
         big_next = s_end;
         fifo_next = s_fifo;
         reg_rd_next = !s_fifo;
         rxf_rd_next = s_fifo;
         fetch1_next = 1'b1;
         pair_next = hbwp_pkg::pair_rd_half;
      end
      // First write half held until its partner comes
      if (do_open) begin
         word_next = from_host('0, s_data, s_addr[1], s_end);
         addr_next = s_addr[ADDR_W-1:2];
         half_next = s_addr[1];
         big_next = s_end;
         fifo_next = s_fifo;
         pair_next = hbwp_pkg::pair_wr_half;
      end
   end

   // Register the pair tracking and access pulses
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         pair_reg <= hbwp_pkg::pair_idle;
         word_reg <= '0;
         addr_reg <= '0;
         half_reg <= 1'b0;
         big_reg <= 1'b0;
         fifo_reg <= 1'b0;
         rd16_reg <= 1'b0;
         rd_seen_reg <= 1'b0;
         fetch1_reg <= 1'b0;
         fetch2_reg <= 1'b0;
         data_out_reg <= '0;
         oe_reg <= 1'b0;
         reg_rd_reg <= 1'b0;
         rxf_rd_reg <= 1'b0;
         reg_wr_reg <= 1'b0;
         txf_wr_reg <= 1'b0;
         wr_data_reg <= '0;
      end else begin
         pair_reg <= pair_next;
         word_reg <= word_next;
         addr_reg <= addr_next;
         half_reg <= half_next;
         big_reg <= big_next;
         fifo_reg <= fifo_next;
         rd16_reg <= rd16_next;
         rd_seen_reg <= rd_seen_next;
         fetch1_reg <= fetch1_next;
         fetch2_reg <= fetch2_next;
         data_out_reg <= data_out_next;
         oe_reg <= oe_next;
         reg_rd_reg <= reg_rd_next;
         rxf_rd_reg <= rxf_rd_next;
         reg_wr_reg <= reg_wr_next;
         txf_wr_reg <= txf_wr_next;
         wr_data_reg <= wr_data_next;
      end
   end

   // Next interrupt status and pin; sources are on clk_sys already
   always_comb begin
      irq_stat_next = irq_src;
      irq_next = |(irq_src & irq_en);
   end

   // Register interrupt status and pin
   always_ff @(posedge clk_sys) begin
      if (!nrst) begin
         irq_stat_reg <= '0;
         irq_reg <= 1'b0;
      end else begin
         irq_stat_reg <= irq_stat_next;
         irq_reg <= irq_next;
      end
   end

   // Outputs straight from flops
   assign host_data_out = data_out_reg;
   assign host_data_oe = oe_reg;
   assign reg_addr = addr_reg;
   assign reg_wr = reg_wr_reg;
   assign reg_rd = reg_rd_reg;
   assign wr_data = wr_data_reg;
   assign txf_wr = txf_wr_reg;
   assign rxf_rd = rxf_rd_reg;
   assign irq_stat = irq_stat_reg;
   assign irq = irq_reg;

endmodule : hbwp_port

/* File: verif/hbwp_props.sv */
// Purpose: Port-level checks of the host bus port
// Assumes: Host strobes last 8 cycles
// Notes: Bound after endmodule
`timescale 1ns/1ps
module hbwp_props #(parameter int IRQ_N = 8) (
   // Clock and reset
   input wire logic clk_sys,
   input wire logic nrst,
   // Watched pins
   input wire logic host_cs_n,
   input wire logic host_data_oe,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic txf_wr,
   input wire logic rxf_rd,
   input wire logic [IRQ_N-1:0] irq_en,
   input wire logic irq
);
   logic [3:0] age_reg, age_next; // Cycles since select, saturating
   // Next age: zero while selected, sync delay covered by bound 8
   always_comb age_next = !host_cs_n ? 4'h0 : age_reg + {3'h0, age_reg != 4'hf};
   // Register age
   always_ff @(posedge clk_sys) age_reg <= !nrst ? 4'hf : age_next;
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (!nrst);
   sequence s_no_wr;
      !reg_wr ##1 !reg_wr;
   endsequence
   chk_wr_once: assert property (reg_wr |=> s_no_wr) else $error("double write");
   chk_txf_once: assert property (txf_wr |=> (!txf_wr)[*2]) else $error("double push");
   chk_wr_route: assert property (!(reg_wr && txf_wr)) else $error("write both");
   chk_rd_route: assert property (!(reg_rd && rxf_rd)) else $error("read both");
   chk_wr_cause: assert property ((reg_wr || txf_wr) |-> age_reg < 4'h8)
      else $error("write unasked");
   chk_rd_cause: assert property ((reg_rd || rxf_rd) |-> age_reg < 4'h8)
      else $error("read unasked");
   chk_oe_cause: assert property (host_data_oe |-> age_reg < 4'h8) else $error("stray oe");
   chk_irq_mask: assert property ((irq_en == '0)[*4] |-> !irq) else $error("masked irq");
endmodule : hbwp_props
bind hbwp_port hbwp_props #(.IRQ_N(IRQ_N)) hbwp_props_i (.clk_sys, .nrst, .host_cs_n,
   .host_data_oe, .reg_wr, .reg_rd, .txf_wr, .rxf_rd, .irq_en, .irq);

/* File: verif/hbwp_host_model.sv */
// Purpose: Host bus master model
// Assumes: 8-cycle strobes, 6 idle
// Notes: Data lines invert when idle
`timescale 1ns/1ps
module hbwp_host_model (
   // Clock
   input wire logic clk_sys,
   // Host pins
   output logic host_cs_n,
   output logic host_rd_n,
   output logic host_wr_n,
   output logic [9:1] host_addr,
   output logic [15:0] host_data_in,
   input wire logic [15:0] host_data_out
);
   // Idle bus at time zero
   initial begin
      {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
      host_addr = 9'h0;
      host_data_in = 16'h0;
   end
   // One 16-bit cycle, data taken at last held edge
   task automatic cyc(input logic rd, input logic [9:1] a, input logic [15:0] d,
         output logic [15:0] q);
      @(negedge clk_sys);
      host_addr = a;
      host_data_in = rd ? ~host_data_in : d;
      {host_cs_n, host_rd_n, host_wr_n} = {1'b0, !rd, rd};
      repeat (8) @(posedge clk_sys);
      q = host_data_out;
      @(negedge clk_sys);
      {host_cs_n, host_rd_n, host_wr_n} = 3'h7;
      {host_addr, host_data_in} = ~{host_addr, host_data_in};
      repeat (6) @(posedge clk_sys);
   endtask : cyc
   // Atomic pair, only A1 differs
   task automatic wr(input logic [7:0] a, input logic h, input logic [31:0] w);
      logic [15:0] q;
      cyc(1'b0, {a, h}, h ? w[31:16] : w[15:0], q);
      cyc(1'b0, {a, !h}, h ? w[15:0] : w[31:16], q);
   endtask : wr
   task automatic rd(input logic [7:0] a, input logic h, output logic [31:0] w);
      logic [15:0] p, q;
      cyc(1'b1, {a, h}, 16'h0, p);
      cyc(1'b1, {a, !h}, 16'h0, q);
      w = h ? {p, q} : {q, p};
   endtask : rd
endmodule : hbwp_host_model

/* File: verif/host_bus_word_pair_port_tb.sv */
// Purpose: Self-checking bench
// Assumes: Little endian, internal side here
// Notes: Waits are fixed by the model
`timescale 1ns/1ps
module host_bus_word_pair_port_tb;
   logic clk_sys = 1'b0, nrst = 1'b0, fifo_sel = 1'b0; // Clock, reset, mode
   logic host_cs_n, host_rd_n, host_wr_n, reg_wr, reg_rd, txf_wr, rxf_rd, irq, oe;
   logic [9:1] host_addr;
   logic [15:0] host_data_in, host_data_out;
   logic [7:0] reg_addr, a_last, irq_stat, irq_src = 8'h00, irq_en = 8'h00;
   logic [31:0] wr_data, w_last, q; // Last write, read word
   logic [31:0] rdata = 32'h8765_4321; // Internal register read data
   logic end_sel = 1'b0, rd16 = 1'b0; // Endian select, 16-bit readable
   int fail_count = 0, n_checks = 0, w_n = 0, t_n = 0;
   hbwp_port hbwp_port_i (.clk_sys, .nrst, .host_cs_n, .host_rd_n, .host_wr_n, .host_addr,
      .host_data_in, .host_data_out, .host_data_oe(oe), .end_sel, .fifo_sel,
      .reg_addr, .reg_wr, .reg_rd, .wr_data, .reg_rdata(rdata), .reg_rd16(rd16),
      .txf_wr, .rxf_rd, .rxf_rdata(32'hcafe_f00d), .irq_src, .irq_en, .irq_stat, .irq);
   hbwp_host_model hbwp_host_model_i (.clk_sys, .host_cs_n, .host_rd_n, .host_wr_n,
      .host_addr, .host_data_in, .host_data_out);
   always #20 clk_sys = ~clk_sys;
   // Internal side: count and capture commits
   always @(posedge clk_sys) begin
      if (reg_wr) begin
         w_n++;
         {a_last, w_last} = {reg_addr, wr_data};
      end
      t_n += txf_wr;
   end
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         fail_count++;
         $display("unexpected %s: expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic test_done;
      $display("checks %0d mismatches %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask : test_done
   // Write before any read is dropped, then both read orders
   task automatic t_reset;
      hbwp_host_model_i.wr(8'h01, 1'b0, 32'h1111_2222);
      chk("early write", 32'h0, w_n);
      hbwp_host_model_i.rd(8'h02, 1'b0, q);
      chk("read lo first", 32'h8765_4321, q);
      hbwp_host_model_i.rd(8'h02, 1'b1, q);
      chk("read hi first", 32'h8765_4321, q);
      $display("t_reset done");
   endtask : t_reset
   // Both write orders, one commit each; repeated half discarded
   task automatic t_wr;
      logic [15:0] h;
      for (int i = 0; i < 2; i++) begin
         hbwp_host_model_i.wr(8'h05, i[0], 32'ha5a5_0f0f ^ i);
         chk("write count", i + 1, w_n);
         chk("write word", 32'ha5a5_0f0f ^ i, w_last);
         chk("write addr", 32'h5, {24'h0, a_last});
      end
      hbwp_host_model_i.cyc(1'b1, 9'h004, 16'h0, h);
      hbwp_host_model_i.cyc(1'b1, 9'h004, 16'h0, h);
      hbwp_host_model_i.rd(8'h02, 1'b0, q);
      chk("reread", 32'h8765_4321, q);
      hbwp_host_model_i.cyc(1'b0, 9'h00a, 16'h1234, h);
      hbwp_host_model_i.cyc(1'b0, 9'h00a, 16'h5678, h);
      chk("same half write", 32'h2, w_n);
      $display("t_wr done");
   endtask : t_wr
   // FIFO select reroutes; interrupt enable gates pin
   task automatic t_fifo_irq;
      @(negedge clk_sys) fifo_sel = 1'b1;
      hbwp_host_model_i.rd(8'h02, 1'b0, q);
      chk("fifo read", 32'hcafe_f00d, q);
      hbwp_host_model_i.wr(8'h07, 1'b0, 32'h0bad_f00d);
      chk("fifo push", 32'h1, t_n);
      @(negedge clk_sys) {fifo_sel, irq_src} = 9'h081;
      repeat (8) @(negedge clk_sys);
      chk("irq masked", 32'h0, {31'h0, irq});
      chk("irq status", 32'h81, {24'h0, irq_stat});
      irq_en = 8'h80;
      repeat (8) @(negedge clk_sys);
      chk("irq enabled", 32'h1, {31'h0, irq});
      $display("t_fifo_irq done");
   endtask : t_fifo_irq
   // Big endian read and write; 16-bit readable half read alone twice
   task automatic t_endian;
      logic [15:0] h;
      @(negedge clk_sys) end_sel = 1'b1;
      hbwp_host_model_i.rd(8'h02, 1'b0, q);
      chk("big read", 32'h2143_6587, q);
      hbwp_host_model_i.wr(8'h09, 1'b0, 32'h1122_3344);
      chk("big write", 32'h4433_2211, w_last);
      @(negedge clk_sys) {end_sel, rd16} = 2'h1;
      hbwp_host_model_i.cyc(1'b1, 9'h004, 16'h0, h);
      chk("single read", 32'h4321, {16'h0, h});
      @(negedge clk_sys) rdata = 32'h8765_aaaa;
      hbwp_host_model_i.cyc(1'b1, 9'h004, 16'h0, h);
      chk("single reread", 32'haaaa, {16'h0, h});
      $display("t_endian done");
   endtask : t_endian
   initial begin
      repeat (4) @(posedge clk_sys);
      @(negedge clk_sys) nrst = 1'b1;
      t_reset;
      t_wr;
      t_fifo_irq;
      t_endian;
      test_done;
   end
   // Watchdog
   initial begin
      #400us;
      fail_count++;
      test_done;
   end
endmodule : host_bus_word_pair_port_tb
